// File: hdl/btbid_cond_branch.sv
/*
 * btbid_cond_branch: matches one five-bit branch prefix and reports
 * whether the word is this branch and whether its condition holds.
 * Purely combinational; assumes the caller registers the result.
 */
`timescale 1ns/1ps
module btbid_cond_branch #(
	parameter logic [4:0] PREFIX = 5'h10
) (
	input wire logic [15:0] instr_word,
	input wire logic cond_bit,
	output logic hit,
	output logic take
);

	// prefix compare; the target field is not looked at here
	assign hit = (instr_word[btbid_pkg::BR_PFX_MSB:btbid_pkg::BR_PFX_LSB] == PREFIX);
	// jump only when the tested bit is one
	assign take = hit & cond_bit;

endmodule : btbid_cond_branch

// File: hdl/btbid_core.sv
/*
 * btbid_core: executes the memory increment and the five conditional
 * branches (four nibble-bit tests and carry) of a 4-bit core.
 *
 * Assumes instruction words come from program memory logic on clk_sys,
 * one word per pulse of instr_valid (the machine-cycle enable).
 */
// Functional notes
// - increment memory, write memory and nibble, flags
// - decode bit0 branch, prefix 10000, target
// - decode bit1 branch, prefix 10010, one cycle
// - bit1 set loads target, else increment
// - decode bit2 branch, prefix 10100, one cycle
// - bit2 set loads target, else increment
// - decode bit3 branch, prefix 10110, one cycle
// - bit3 set loads target, else increment
// - decode carry branch, prefix 1110 plus bit
// - carry set loads target, else increment
// - seven-bit field selects one data nibble
`timescale 1ns/1ps
module btbid_core (
	input wire logic clk_sys,
	input wire logic reset,
	// program memory side
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	output logic [10:0] fetch_addr,
	// writes from the rest of the core, used when no word executes, and a peek read port that is always live
	input wire logic work_nibble_load,
	input wire logic [3:0] work_nibble_load_data,
	input wire logic carry_flag_load,
	input wire logic carry_flag_load_data,
	input wire logic mem_load,
	input wire logic [6:0] mem_load_addr,
	input wire logic [3:0] mem_load_data,
	input wire logic [6:0] mem_peek_addr,
	output logic [3:0] mem_peek_data,
	// architectural state
	output logic [3:0] work_nibble,
	output logic carry_flag,
	output logic zero_flag,
	// one-cycle status pulses for the executed word
	output logic inc_done,
	output logic branch_hit,
	output logic branch_taken,
	output logic other_op
);

	// ==========================================================
	// state registers
	logic [10:0] pc_ff;
	logic [10:0] nxt_pc;
	logic [3:0] work_nibble_ff;
	logic [3:0] nxt_work_nibble;
	logic carry_flag_ff;
	logic nxt_carry_flag;
	logic zero_flag_ff;
	logic nxt_zero_flag;
	logic inc_done_ff;
	logic nxt_inc_done;
	logic branch_hit_ff;
	logic nxt_branch_hit;
	logic branch_taken_ff;
	logic nxt_branch_taken;
	logic other_op_ff;
	logic nxt_other_op;

	// ==========================================================
	// decode wires
	logic [4:0] br_hit;
	logic [4:0] br_take;
	logic [4:0] br_cond;
	logic any_br_hit;
	logic any_br_take;
	logic inc_match;
	btbid_pkg::btbid_op_e op_kind;
	logic [6:0] operand_addr;
	logic [10:0] target;
	logic [3:0] operand_nibble;
	logic [4:0] inc_sum;
	logic ram_wr_en;
	logic [6:0] ram_wr_addr;
	logic [3:0] ram_wr_data;

	// ==========================================================
	// instruction fields
	// operand field indexes
	assign operand_addr = instr_word[btbid_pkg::RADDR_MSB:btbid_pkg::RADDR_LSB];
	assign target = instr_word[btbid_pkg::TGT_MSB:btbid_pkg::TGT_LSB];
	assign inc_match = (instr_word[btbid_pkg::INC_PFX_MSB:btbid_pkg::INC_PFX_LSB]
		== btbid_pkg::OP_INC_MEM);

	// ==========================================================
	// branch matchers
	// the tested conditions, lowest index first: nibble bits 0..3, then carry
	assign br_cond = {carry_flag_ff, work_nibble_ff};

	btbid_cond_branch #(
		.PREFIX(btbid_pkg::OP_BR_BIT0)
	) u_br_bit0 (
		.instr_word(instr_word),
		.cond_bit(br_cond[0]),
		.hit(br_hit[0]),
		.take(br_take[0])
	);

	btbid_cond_branch #(
		.PREFIX(btbid_pkg::OP_BR_BIT1)
	) u_br_bit1 (
		.instr_word(instr_word),
		.cond_bit(br_cond[1]),
		.hit(br_hit[1]),
		.take(br_take[1])
	);

	btbid_cond_branch #(
		.PREFIX(btbid_pkg::OP_BR_BIT2)
	) u_br_bit2 (
		.instr_word(instr_word),
		.cond_bit(br_cond[2]),
		.hit(br_hit[2]),
		.take(br_take[2])
	);

	btbid_cond_branch #(
		.PREFIX(btbid_pkg::OP_BR_BIT3)
	) u_br_bit3 (
		.instr_word(instr_word),
		.cond_bit(br_cond[3]),
		.hit(br_hit[3]),
		.take(br_take[3])
	);

	// carry branch matcher
	// the fifth prefix bit is assumed; change OP_BR_CARRY once confirmed
	btbid_cond_branch #(
		.PREFIX(btbid_pkg::OP_BR_CARRY)
	) u_br_carry (
		.instr_word(instr_word),
		.cond_bit(br_cond[4]),
		.hit(br_hit[4]),
		.take(br_take[4])
	);

	assign any_br_hit = |br_hit;
	assign any_br_take = |br_take;

	// ==========================================================
	// data memory
	// the increment reads and writes the same cell in one cycle
	btbid_data_ram u_ram (
		.clk_sys(clk_sys),
		.reset(reset),
		.rd_addr(operand_addr),
		.rd_data(operand_nibble),
		.rd2_addr(mem_peek_addr),
		.rd2_data(mem_peek_data),
		.wr_en(ram_wr_en),
		.wr_addr(ram_wr_addr),
		.wr_data(ram_wr_data)
	);

	assign inc_sum = {1'b0, operand_nibble} + btbid_pkg::NIB_ONE;

	// ==========================================================
	// classify the word of this machine cycle
	always_comb begin
		if (!instr_valid) begin
			op_kind = btbid_pkg::BTBID_OP_NONE;
		end else if (inc_match) begin
			op_kind = btbid_pkg::BTBID_OP_INC;
		end else if (any_br_hit) begin
			op_kind = btbid_pkg::BTBID_OP_BRANCH;
		end else begin
			op_kind = btbid_pkg::BTBID_OP_OTHER;
		end
	end

	// memory write: an executing increment wins over a side load,
	// since both land on the same port and the word is architectural
	always_comb begin
		ram_wr_en = 1'b0;
		ram_wr_addr = mem_load_addr;
		ram_wr_data = mem_load_data;
		if (op_kind == btbid_pkg::BTBID_OP_INC) begin
			ram_wr_en = 1'b1;
			ram_wr_addr = operand_addr;
			ram_wr_data = inc_sum[3:0];
		end else if (!instr_valid) begin
			ram_wr_en = mem_load;
		end
	end

	// ==========================================================
	// program counter group
	// every case finishes in one machine cycle; no wait states exist
	always_comb begin
		nxt_pc = pc_ff;
		case (op_kind)
			btbid_pkg::BTBID_OP_NONE: begin
				nxt_pc = pc_ff;
			end
			btbid_pkg::BTBID_OP_BRANCH: begin
				if (any_br_take) begin
					nxt_pc = target;
				end else begin
					nxt_pc = pc_ff + btbid_pkg::PC_STEP;
				end
			end
			btbid_pkg::BTBID_OP_INC,
			btbid_pkg::BTBID_OP_OTHER: begin
				nxt_pc = pc_ff + btbid_pkg::PC_STEP;
			end
			default: begin
				nxt_pc = pc_ff;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pc_ff <= btbid_pkg::PC_RESET;
		end else begin
			pc_ff <= nxt_pc;
		end
	end

	// ==========================================================
	// nibble register and flags group
	always_comb begin
		nxt_work_nibble = work_nibble_ff;
		nxt_carry_flag = carry_flag_ff;
		nxt_zero_flag = zero_flag_ff;
		case (op_kind)
			btbid_pkg::BTBID_OP_INC: begin
				nxt_work_nibble = inc_sum[3:0];
				nxt_carry_flag = inc_sum[4];
				nxt_zero_flag = (inc_sum[3:0] == btbid_pkg::NIB_RESET);
			end
			btbid_pkg::BTBID_OP_NONE: begin
				// side loads only act between executed words
				if (work_nibble_load) begin
					nxt_work_nibble = work_nibble_load_data;
					nxt_zero_flag = (work_nibble_load_data == btbid_pkg::NIB_RESET);
				end
				if (carry_flag_load) begin
					nxt_carry_flag = carry_flag_load_data;
				end
			end
			btbid_pkg::BTBID_OP_BRANCH,
			btbid_pkg::BTBID_OP_OTHER: begin
				// branches leave the nibble and flags untouched
				nxt_work_nibble = work_nibble_ff;
			end
			default: begin
				nxt_work_nibble = work_nibble_ff;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			work_nibble_ff <= btbid_pkg::NIB_RESET;
			carry_flag_ff <= btbid_pkg::FLAG_RESET;
			zero_flag_ff <= btbid_pkg::FLAG_RESET;
		end else begin
			work_nibble_ff <= nxt_work_nibble;
			carry_flag_ff <= nxt_carry_flag;
			zero_flag_ff <= nxt_zero_flag;
		end
	end

	// ==========================================================
	// status pulse group
	// pulses are registered so they line up with the new state
	always_comb begin
		nxt_inc_done = (op_kind == btbid_pkg::BTBID_OP_INC);
		nxt_branch_hit = (op_kind == btbid_pkg::BTBID_OP_BRANCH);
		nxt_branch_taken = (op_kind == btbid_pkg::BTBID_OP_BRANCH) & any_br_take;
		nxt_other_op = (op_kind == btbid_pkg::BTBID_OP_OTHER);
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			inc_done_ff <= 1'b0;
			branch_hit_ff <= 1'b0;
			branch_taken_ff <= 1'b0;
			other_op_ff <= 1'b0;
		end else begin
			inc_done_ff <= nxt_inc_done;
			branch_hit_ff <= nxt_branch_hit;
			branch_taken_ff <= nxt_branch_taken;
			other_op_ff <= nxt_other_op;
		end
	end

	// ==========================================================
	// outputs
	assign fetch_addr = pc_ff;
	assign work_nibble = work_nibble_ff;
	assign carry_flag = carry_flag_ff;
	assign zero_flag = zero_flag_ff;
	assign inc_done = inc_done_ff;
	assign branch_hit = branch_hit_ff;
	assign branch_taken = branch_taken_ff;
	assign other_op = other_op_ff;

endmodule : btbid_core

// File: hdl/btbid_data_ram.sv
/*
 * btbid_data_ram: 128 x 4 data memory built from flip-flops.
 * Asynchronous read by index, one write per clock.
 * Assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module btbid_data_ram (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [6:0] rd_addr,
	output logic [3:0] rd_data,
	input wire logic [6:0] rd2_addr,
	output logic [3:0] rd2_data,
	input wire logic wr_en,
	input wire logic [6:0] wr_addr,
	input wire logic [3:0] wr_data
);

	// ==========================================================
	// storage
	logic [3:0] mem_ff [btbid_pkg::RAM_DEPTH];
	logic [3:0] nxt_mem [btbid_pkg::RAM_DEPTH];

	// read ports see the stored value, not the word being written
	assign rd_data = mem_ff[rd_addr];
	assign rd2_data = mem_ff[rd2_addr];

	// next value: only the addressed cell changes
	always_comb begin
		for (int i = 0; i < btbid_pkg::RAM_DEPTH; i++) begin
			nxt_mem[i] = mem_ff[i];
		end
		if (wr_en) begin
			nxt_mem[wr_addr] = wr_data;
		end
	end

	// reset clears memory so simulation starts from known contents
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < btbid_pkg::RAM_DEPTH; i++) begin
			if (reset) begin
				mem_ff[i] <= btbid_pkg::NIB_RESET;
			end else begin
				mem_ff[i] <= nxt_mem[i];
			end
		end
	end

endmodule : btbid_data_ram

// File: hdl/btbid_pkg.sv
/*
 * btbid_pkg: shared constants for the bit-test branch and increment decoder.
 * Holds opcode prefixes, field positions, widths and reset values.
 * Assumes the user compiles it before every other design file.
 */
package btbid_pkg;

	// ==========================================================
	// widths
	localparam int unsigned INSTR_W = 16;
	localparam int unsigned PC_W = 11;
	localparam int unsigned NIB_W = 4;
	localparam int unsigned RADDR_W = 7;
	localparam int unsigned RAM_DEPTH = 128;
	localparam int unsigned BR_COUNT = 5;

	// ==========================================================
	// field positions inside the instruction word
	localparam int unsigned INC_PFX_MSB = 15;
	localparam int unsigned INC_PFX_LSB = 7;
	localparam int unsigned BR_PFX_MSB = 15;
	localparam int unsigned BR_PFX_LSB = 11;
	localparam int unsigned TGT_MSB = 10;
	localparam int unsigned TGT_LSB = 0;
	localparam int unsigned RADDR_MSB = 6;
	localparam int unsigned RADDR_LSB = 0;

	// ==========================================================
	// opcode prefixes
	localparam logic [8:0] OP_INC_MEM = 9'h094;
	localparam logic [4:0] OP_BR_BIT0 = 5'h10;
	localparam logic [4:0] OP_BR_BIT1 = 5'h12;
	localparam logic [4:0] OP_BR_BIT2 = 5'h14;
	localparam logic [4:0] OP_BR_BIT3 = 5'h16;
	// carry prefix 1110 widened to five bits; the added bit is assumed
	localparam logic [4:0] OP_BR_CARRY = 5'h1e;

	// ==========================================================
	// reset values and step constants
	localparam logic [10:0] PC_RESET = 11'h000;
	localparam logic [3:0] NIB_RESET = 4'h0;
	localparam logic FLAG_RESET = 1'b0;
	localparam logic [10:0] PC_STEP = 11'h001;
	localparam logic [4:0] NIB_ONE = 5'h01;

	// decode result of the current word
	typedef enum logic [1:0] {
		BTBID_OP_NONE = 2'b00,
		BTBID_OP_INC = 2'b01,
		BTBID_OP_BRANCH = 2'b10,
		BTBID_OP_OTHER = 2'b11
	} btbid_op_e;

endpackage : btbid_pkg

// File: verification/bit_test_branch_increment_decode_tb.sv
/*
 * bit_test_branch_increment_decode_tb: directed bench for btbid_core.
 * Assumes a 50 MHz clk_sys and the program memory model beside the core.
 */
`timescale 1ns/1ps
module bit_test_branch_increment_decode_tb;
	logic clk_sys, reset, iv, wn_ld, cf_ld, cf_d, m_ld, cf, zf, inc_done, br_hit, br_tk, oth;
	logic [3:0] wn_d, m_d, pk_d, wn;
	logic [6:0] m_a, pk_a;
	logic [10:0] fa, p;
	logic [15:0] iw;
	int num_errors, num_checks;
	btbid_prog_mem i_btbid_prog_mem (.fetch_addr(fa), .instr_word(iw));
	btbid_core i_btbid_core (.clk_sys(clk_sys), .reset(reset), .instr_valid(iv),
		.instr_word(iw), .fetch_addr(fa), .work_nibble_load(wn_ld),
		.work_nibble_load_data(wn_d), .carry_flag_load(cf_ld), .carry_flag_load_data(cf_d),
		.mem_load(m_ld), .mem_load_addr(m_a), .mem_load_data(m_d), .mem_peek_addr(pk_a),
		.mem_peek_data(pk_d), .work_nibble(wn), .carry_flag(cf), .zero_flag(zf),
		.inc_done(inc_done), .branch_hit(br_hit), .branch_taken(br_tk), .other_op(oth));
	// ==========================================================
	// helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test
	task automatic step();
		@(posedge clk_sys);
		#1;
	endtask : step
	// side loads only land while no word executes
	task automatic side(input logic [3:0] n, input logic c);
		iv = 1'b0;
		wn_ld = 1'b1;
		wn_d = n;
		cf_ld = 1'b1;
		cf_d = c;
		step();
		wn_ld = 1'b0;
		cf_ld = 1'b0;
	endtask : side
	// leaves the valid strobe up so words can follow back to back
	task automatic run(input logic [15:0] w);
		i_btbid_prog_mem.mem[fa] = w;
		iv = 1'b1;
		step();
	endtask : run
	// callers leave the valid strobe low before a reset
	task automatic t_reset();
		reset = 1'b1;
		repeat (10) step();
		reset = 1'b0;
		chk(16'(fa), 16'h0000);
		chk(16'({wn, cf, zf, inc_done, br_hit, br_tk, oth}), 16'h0000);
		chk(16'(pk_d), 16'h0000);
	endtask : t_reset
	// two increments in a row across the top of the nibble
	task automatic t_inc();
		m_a = 7'h7f;
		m_d = 4'he;
		m_ld = 1'b1;
		step();
		m_ld = 1'b0;
		p = fa;
		run(16'h4a7f);
		chk(16'(wn), 16'h000f);
		chk(16'(pk_d), 16'h000f);
		chk(16'({cf, zf, inc_done}), 16'h0001);
		run(16'h4a7f);
		chk(16'({wn, pk_d}), 16'h0000);
		chk(16'({cf, zf, inc_done}), 16'h0007);
		chk(16'(fa), 16'(p + 11'h002));
		iv = 1'b0;
		step();
		pk_a = 7'h7e;
		step();
		chk(16'(pk_d), 16'h0000);
		pk_a = 7'h7f;
	endtask : t_inc
	// every branch, taken then not taken with all other bits against it
	task automatic t_br();
		logic [4:0] ops [5];
		logic [3:0] b;
		ops = '{5'h10, 5'h12, 5'h14, 5'h16, 5'h1e};
		for (int i = 0; i < 5; i++) begin
			b = 4'h1 << i;
			side(b, i == 4);
			run({ops[i], 11'h7f0 + 11'(i)});
			chk(16'(fa), 16'(11'h7f0 + 11'(i)));
			chk(16'({br_hit, br_tk, oth}), 16'h0006);
			side(~b, i < 4);
			p = fa;
			run({ops[i], 11'h123});
			chk(16'(fa), 16'(p + 11'h001));
			chk(16'({br_hit, br_tk}), 16'h0002);
		end
	endtask : t_br
	// side loads offered during an executing word are all refused
	task automatic t_oth();
		side(4'h9, 1'b0);
		step();
		p = fa;
		wn_ld = 1'b1;
		wn_d = 4'h5;
		cf_ld = 1'b1;
		cf_d = 1'b1;
		m_ld = 1'b1;
		m_a = 7'h7f;
		m_d = 4'h3;
		run(16'h0000);
		{wn_ld, cf_ld, m_ld} = 3'h0;
		iv = 1'b0;
		chk(16'({oth, br_hit, inc_done, wn}), 16'h0049);
		chk(16'({cf, pk_d}), 16'h0000);
		chk(16'(fa), 16'(p + 11'h001));
	endtask : t_oth
	// ==========================================================
	// clock, stimulus and watchdog
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		{iv, wn_ld, cf_ld, cf_d, m_ld} = 5'h00;
		{wn_d, m_d, m_a, pk_a} = 22'h00007f;
		t_reset();
		t_inc();
		t_br();
		t_oth();
		t_reset();
		finish_test();
	end
	// the whole run is well under a thousand cycles
	initial begin
		#40000;
		num_errors++;
		finish_test();
	end
endmodule : bit_test_branch_increment_decode_tb

// File: verification/btbid_core_checker.sv
/*
 * btbid_core_checker: assertions on the ports of btbid_core.
 * Assumes one clk_sys domain and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module btbid_core_checker (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	input wire logic [10:0] fetch_addr,
	input wire logic [6:0] mem_peek_addr,
	input wire logic [3:0] mem_peek_data,
	input wire logic [3:0] work_nibble,
	input wire logic carry_flag,
	input wire logic zero_flag,
	input wire logic inc_done,
	input wire logic branch_hit,
	input wire logic branch_taken,
	input wire logic other_op
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	// ==========================================================
	// decode helpers; the increment is only checked when peek watches its cell
	logic [4:0] pfx;
	logic is_inc;
	assign pfx = instr_word[15:11];
	assign is_inc = instr_valid && instr_word[15:7] == 9'h094;
	property p_inc;
		is_inc && mem_peek_addr == instr_word[6:0] |=> inc_done && mem_peek_data == work_nibble
			&& work_nibble == $past(mem_peek_data) + 4'h1 && zero_flag == (work_nibble == 4'h0)
			&& carry_flag == ($past(mem_peek_data) == 4'hf);
	endproperty
	a_inc: assert property (p_inc) else $error("increment result wrong");
	property p_br0;
		instr_valid && pfx == 5'h10 |=> branch_hit && fetch_addr ==
			($past(work_nibble[0]) ? $past(instr_word[10:0]) : $past(fetch_addr) + 11'h001);
	endproperty
	a_br0: assert property (p_br0) else $error("bit0 branch wrong");
	property p_br1;
		instr_valid && pfx == 5'h12 |=> branch_taken == $past(work_nibble[1]);
	endproperty
	a_br1: assert property (p_br1) else $error("bit1 branch taken flag wrong");
	property p_br2;
		instr_valid && pfx == 5'h14 && !work_nibble[2] |=> fetch_addr == $past(fetch_addr) + 11'h001;
	endproperty
	a_br2: assert property (p_br2) else $error("bit2 branch should step");
	property p_br3;
		instr_valid && pfx == 5'h16 && work_nibble[3] |=> fetch_addr == $past(instr_word[10:0]);
	endproperty
	a_br3: assert property (p_br3) else $error("bit3 branch should jump");
	property p_brc;
		instr_valid && pfx == 5'h1e |=> branch_hit && branch_taken == $past(carry_flag) && fetch_addr ==
			($past(carry_flag) ? $past(instr_word[10:0]) : $past(fetch_addr) + 11'h001);
	endproperty
	a_brc: assert property (p_brc) else $error("carry branch wrong");
	property p_one;
		!instr_valid |=> !branch_hit && !inc_done && !other_op && $stable(fetch_addr);
	endproperty
	a_one: assert property (p_one) else $error("activity without a word");
	property p_oth;
		instr_valid && !instr_word[15] && !is_inc |=> other_op ##0 !branch_hit;
	endproperty
	a_oth: assert property (p_oth) else $error("foreign word misdecoded");
	c_inc_wrap: cover property (is_inc && mem_peek_data == 4'hf);
	c_carry: cover property (instr_valid && pfx == 5'h1e && carry_flag);
	c_taken: cover property (branch_taken);
endmodule : btbid_core_checker

bind btbid_core btbid_core_checker i_btbid_core_checker (.clk_sys(clk_sys), .reset(reset),
	.instr_valid(instr_valid), .instr_word(instr_word), .fetch_addr(fetch_addr),
	.mem_peek_addr(mem_peek_addr), .mem_peek_data(mem_peek_data), .work_nibble(work_nibble),
	.carry_flag(carry_flag), .zero_flag(zero_flag), .inc_done(inc_done),
	.branch_hit(branch_hit), .branch_taken(branch_taken), .other_op(other_op));

// File: verification/btbid_prog_mem.sv
/*
 * btbid_prog_mem: program memory model, 2048 words of 16 bits.
 * Assumes the bench writes each word before the core fetches it.
 */
`timescale 1ns/1ps
module btbid_prog_mem (
	input wire logic [10:0] fetch_addr,
	output logic [15:0] instr_word
);
	logic [15:0] mem [0:2047];
	// ==========================================================
	// unwritten words are zero, which decode as none of ours
	initial begin
		for (int i = 0; i < 2048; i++) begin
			mem[i] = 16'h0000;
		end
	end
	// asynchronous read; the word follows the program counter at once
	assign instr_word = mem[fetch_addr];
endmodule : btbid_prog_mem
